// >>> hdl/tm8_pkg.sv
// Constants, types and helpers shared by the eight-bit timer control block
package tm8_pkg;

  // Register indices; byte address is four times the index
  localparam logic [13:0] TM8_IDX_CTRL = 14'h0d00;
  localparam logic [13:0] TM8_IDX_AUX  = 14'h0d03;
  localparam logic [13:0] TM8_IDX_HLO  = 14'h0d04;
  localparam logic [13:0] TM8_IDX_HHI  = 14'h0d05;
  localparam logic [13:0] TM8_IDX_IST  = 14'h0d10;
  localparam logic [13:0] TM8_IDX_IMK  = 14'h0d11;

  // Field positions inside written bytes
  localparam int TM8_BIT_TOUT    = 5;
  localparam int TM8_BIT_AUX_RUN = 6;
  localparam int TM8_IRQ_TOUT    = 0;
  localparam int TM8_IRQ_CAP     = 1;

  // Reset values and constants
  localparam logic [7:0]  TM8_CTRL_RST = 8'h00;
  localparam logic [7:0]  TM8_BYTE_RST = 8'h00;
  localparam logic [7:0]  TM8_TC       = 8'h00;
  localparam logic [7:0]  TM8_ONE      = 8'h01;
  localparam logic [1:0]  TM8_IRQ_RST  = 2'h0;
  localparam logic [23:0] TM8_RD_PAD   = 24'h00_0000;
  localparam logic [5:0]  TM8_IST_PAD  = 6'h00;
  localparam logic [2:0]  TM8_PRE_RST  = 3'h0;
  localparam logic [2:0]  TM8_PRE_ONE  = 3'h1;

  // Prescale codes and their tick masks
  localparam logic [1:0] TM8_DIV1 = 2'h0;
  localparam logic [1:0] TM8_DIV2 = 2'h1;
  localparam logic [1:0] TM8_DIV4 = 2'h2;
  localparam logic [1:0] TM8_DIV8 = 2'h3;
  localparam logic [2:0] TM8_MSK1 = 3'h0;
  localparam logic [2:0] TM8_MSK2 = 3'h1;
  localparam logic [2:0] TM8_MSK4 = 3'h3;
  localparam logic [2:0] TM8_MSK8 = 3'h7;

  typedef enum logic [2:0] {
    TM8_SEL_NONE, TM8_SEL_CTRL, TM8_SEL_AUX,
    TM8_SEL_HLO, TM8_SEL_HHI, TM8_SEL_IST, TM8_SEL_IMK
  } tm8_sel_t;

  typedef struct packed {
    logic       run;
    logic       pass;
    logic       tout;
    logic [1:0] presc;
    logic       cap_mask;
    logic       cnt_mask;
    logic       route;
  } tm8_ctrl_t;

  typedef struct packed {
    tm8_ctrl_t  ctrl;
    logic       aux_run;
    logic [7:0] hold_lo;
    logic [7:0] hold_hi;
    logic [7:0] cnt;
    logic       out;
    logic       active;
    logic       halted;
    logic [1:0] irq_st;
    logic [1:0] irq_mk;
    logic       ack;
    logic [7:0] rdat;
    logic       pin;
  } tm8_state_t;

  typedef struct packed {
    logic [2:0] cnt;
  } tm8_pre_state_t;

  function automatic tm8_sel_t tm8_decode(input logic [13:0] idx);
    case (idx)
      TM8_IDX_CTRL: tm8_decode = TM8_SEL_CTRL;
      TM8_IDX_AUX:  tm8_decode = TM8_SEL_AUX;
      TM8_IDX_HLO:  tm8_decode = TM8_SEL_HLO;
      TM8_IDX_HHI:  tm8_decode = TM8_SEL_HHI;
      TM8_IDX_IST:  tm8_decode = TM8_SEL_IST;
      TM8_IDX_IMK:  tm8_decode = TM8_SEL_IMK;
      default:      tm8_decode = TM8_SEL_NONE;
    endcase
  endfunction

  function automatic logic [2:0] tm8_div_mask(input logic [1:0] sel);
    case (sel)
      TM8_DIV1: tm8_div_mask = TM8_MSK1;
      TM8_DIV2: tm8_div_mask = TM8_MSK2;
      TM8_DIV4: tm8_div_mask = TM8_MSK4;
      default:  tm8_div_mask = TM8_MSK8;
    endcase
  endfunction

endpackage

// >>> hdl/tm8_prescale.sv
// Prescaler that turns the system clock into a counter tick enable
`timescale 1ns/1ps
`default_nettype none
module tm8_prescale
  import tm8_pkg::*;
(
  // Clock and reset
  input  wire logic       sys_clk,
  input  wire logic       rst,
  // Control
  input  wire logic       run,
  input  wire logic [1:0] sel,
  // Tick enable
  output logic            tick
);

  tm8_pre_state_t s_q;
  tm8_pre_state_t s_d;
  logic [2:0]     mask;

  assign mask = tm8_div_mask(sel);
  // One tick every 1, 2, 4 or 8 cycles, phase restarts when stopped
  assign tick = run & ((s_q.cnt & mask) == mask);

  always_comb
  begin
    s_d = s_q;
    if (run)
    begin
      s_d.cnt = s_q.cnt + TM8_PRE_ONE;
    end
    else
    begin
      s_d.cnt = TM8_PRE_RST;
    end
  end

  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      s_q.cnt <= TM8_PRE_RST;
    end
    else
    begin
      s_q <= s_d;
    end
  end

endmodule
`default_nettype wire

// >>> hdl/tm8_timer.sv
// Eight-bit counter/timer control block with a classic Wishbone slave
//
// Register access over Wishbone is this design's own decision.
`timescale 1ns/1ps
`default_nettype none
module tm8_timer
  import tm8_pkg::*;
(
  // Clock and reset
  input  wire logic        sys_clk,
  input  wire logic        rst,
  // Wishbone slave
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [15:0] wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  // Chip side, all on sys_clk
  input  wire logic        stop_recovery,
  input  wire logic        capture_strobe,
  input  wire logic        port_data,
  output logic             port3_pin4,
  output logic             irq
);

  tm8_state_t s_q;
  tm8_state_t s_d;
  tm8_sel_t   sel;
  logic       wb_req;
  logic       wr;
  logic       wr_ctrl;
  logic       wr_aux;
  logic       wr_ist;
  logic       run_any;
  logic       tick;
  logic       counting;
  logic       terminal;
  logic [7:0] wbyte;
  logic [7:0] next_hold;
  logic [1:0] irq_set;

  // Bus request decode
  assign sel     = tm8_decode(wb_adr_i[15:2]);
  assign wb_req  = wb_cyc_i & wb_stb_i & ~s_q.ack;
  assign wr      = wb_req & wb_we_i & wb_sel_i[0];
  assign wbyte   = wb_dat_i[7:0];
  assign wr_ctrl = wr & (sel == TM8_SEL_CTRL);
  assign wr_aux  = wr & (sel == TM8_SEL_AUX);
  assign wr_ist  = wr & (sel == TM8_SEL_IST);

  // Either run bit keeps the counter going
  assign run_any  = s_q.ctrl.run | s_q.aux_run;
  assign counting = run_any & s_q.active & ~s_q.halted;
  assign terminal = counting & tick & (s_q.cnt == TM8_TC);

  // Value for the output level that follows a terminal count
  assign next_hold = s_q.out ? s_q.hold_lo : s_q.hold_hi;

  // Events gated by the control masks
  assign irq_set[TM8_IRQ_TOUT] = terminal & s_q.ctrl.cnt_mask;
  assign irq_set[TM8_IRQ_CAP]  = capture_strobe & s_q.ctrl.cap_mask;

  tm8_prescale u_prescale (
    .sys_clk (sys_clk),
    .rst     (rst),
    .run     (counting),
    .sel     (s_q.ctrl.presc),
    .tick    (tick)
  );

  always_comb
  begin
    s_d     = s_q;
    s_d.ack = wb_req;

    // Register writes
    if (wr_ctrl)
    begin
      // Time-out bit is handled below, its write means clear
      s_d.ctrl      = tm8_ctrl_t'(wbyte);
      s_d.ctrl.tout = s_q.ctrl.tout;
    end
    if (wr_aux)
    begin
      s_d.aux_run = wbyte[TM8_BIT_AUX_RUN];
    end
    if (wr & (sel == TM8_SEL_HLO))
    begin
      s_d.hold_lo = wbyte;
    end
    if (wr & (sel == TM8_SEL_HHI))
    begin
      s_d.hold_hi = wbyte;
    end
    if (wr & (sel == TM8_SEL_IMK))
    begin
      s_d.irq_mk = wbyte[1:0];
    end

    // Sticky time-out: writing one clears, a new terminal count wins
    if (wr_ctrl & wbyte[TM8_BIT_TOUT])
    begin
      s_d.ctrl.tout = 1'b0;
    end
    if (terminal)
    begin
      s_d.ctrl.tout = 1'b1;
    end

    // Interrupt status, write one to clear, set wins
    s_d.irq_st = (s_q.irq_st & ~(wr_ist ? wbyte[1:0] : TM8_IRQ_RST)) | irq_set;

    // Counter sequencing
    if (!run_any)
    begin
      s_d.active = 1'b0;
      s_d.halted = 1'b0;
    end
    else if (!s_q.active)
    begin
      s_d.active = 1'b1;
      s_d.cnt    = s_q.out ? s_q.hold_hi : s_q.hold_lo;
    end
    else if (terminal)
    begin
      s_d.out = ~s_q.out;
      if (s_q.ctrl.pass)
      begin
        s_d.halted = 1'b1;
      end
      else
      begin
        s_d.cnt = next_hold;
      end
    end
    else if (counting & tick)
    begin
      s_d.cnt = s_q.cnt - TM8_ONE;
    end

    // Stop-mode recovery clears all but prescale, masks, holds and count
    if (stop_recovery)
    begin
      s_d.ctrl.run   = 1'b0;
      s_d.ctrl.pass  = 1'b0;
      s_d.ctrl.tout  = 1'b0;
      s_d.ctrl.route = 1'b0;
      s_d.aux_run    = 1'b0;
      s_d.active     = 1'b0;
      s_d.halted     = 1'b0;
      s_d.out        = 1'b0;
      s_d.irq_st     = TM8_IRQ_RST;
    end

    // Read data, unmapped reads return zero
    case (sel)
      TM8_SEL_CTRL: s_d.rdat = s_q.ctrl;
      TM8_SEL_AUX:  s_d.rdat = {1'b0, s_q.aux_run, TM8_IST_PAD};
      TM8_SEL_HLO:  s_d.rdat = s_q.hold_lo;
      TM8_SEL_HHI:  s_d.rdat = s_q.hold_hi;
      TM8_SEL_IST:  s_d.rdat = {TM8_IST_PAD, s_q.irq_st};
      TM8_SEL_IMK:  s_d.rdat = {TM8_IST_PAD, s_q.irq_mk};
      default:      s_d.rdat = TM8_BYTE_RST;
    endcase
    if (!wb_req)
    begin
      s_d.rdat = s_q.rdat;
    end

    // Pin mux
    s_d.pin = s_q.ctrl.route ? s_q.out : port_data;
  end

  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      s_q.ctrl    <= TM8_CTRL_RST;
      s_q.aux_run <= 1'b0;
      s_q.hold_lo <= TM8_BYTE_RST;
      s_q.hold_hi <= TM8_BYTE_RST;
      s_q.cnt     <= TM8_BYTE_RST;
      s_q.out     <= 1'b0;
      s_q.active  <= 1'b0;
      s_q.halted  <= 1'b0;
      s_q.irq_st  <= TM8_IRQ_RST;
      s_q.irq_mk  <= TM8_IRQ_RST;
      s_q.ack     <= 1'b0;
      s_q.rdat    <= TM8_BYTE_RST;
      s_q.pin     <= 1'b0;
    end
    else
    begin
      s_q <= s_d;
    end
  end

  assign wb_ack_o   = s_q.ack;
  assign wb_dat_o   = {TM8_RD_PAD, s_q.rdat};
  assign port3_pin4 = s_q.pin;
  assign irq        = |(s_q.irq_st & s_q.irq_mk);

  // Checks

  sequence s_mod_term;
    terminal && !s_q.ctrl.pass;
  endsequence

  sequence s_one_term;
    terminal && s_q.ctrl.pass;
  endsequence

  property p_stop;
    @(posedge sys_clk) disable iff (rst)
      !run_any |=> !s_q.active && $stable(s_q.cnt);
  endproperty
  a_stop: assert property (p_stop) else $error("counter moved while disabled");

  property p_reload;
    @(posedge sys_clk) disable iff (rst)
      s_mod_term and (!stop_recovery) |=>
        (s_q.out != $past(s_q.out)) && (s_q.cnt == $past(next_hold)) && !s_q.halted;
  endproperty
  a_reload: assert property (p_reload) else $error("no reload at terminal count");

  property p_single;
    @(posedge sys_clk) disable iff (rst)
      s_one_term ##1 (run_any && !stop_recovery)[*3] |-> $stable(s_q.cnt) && s_q.halted;
  endproperty
  a_single: assert property (p_single) else $error("single pass did not halt");

  property p_tout_set;
    @(posedge sys_clk) disable iff (rst)
      terminal && !stop_recovery |=> s_q.ctrl.tout;
  endproperty
  a_tout_set: assert property (p_tout_set) else $error("time-out not set");

  property p_tout_keep;
    @(posedge sys_clk) disable iff (rst)
      s_q.ctrl.tout && !stop_recovery && !(wr_ctrl && wbyte[TM8_BIT_TOUT]) |=> s_q.ctrl.tout;
  endproperty
  a_tout_keep: assert property (p_tout_keep) else $error("time-out lost");

  property p_tout_clr;
    @(posedge sys_clk) disable iff (rst)
      wr_ctrl && wbyte[TM8_BIT_TOUT] && !terminal |=> !s_q.ctrl.tout;
  endproperty
  a_tout_clr: assert property (p_tout_clr) else $error("time-out not cleared");

  property p_div2;
    @(posedge sys_clk) disable iff (rst)
      tick && (s_q.ctrl.presc == TM8_DIV2) && !wr_ctrl |=> !tick;
  endproperty
  a_div2: assert property (p_div2) else $error("divide by two ticked twice");

  property p_smr;
    @(posedge sys_clk) disable iff (rst)
      stop_recovery && !wr_ctrl |=>
        $stable(s_q.ctrl.presc) && $stable(s_q.ctrl.cap_mask) && $stable(s_q.ctrl.cnt_mask)
        && !s_q.ctrl.run && !s_q.ctrl.tout;
  endproperty
  a_smr: assert property (p_smr) else $error("recovery disturbed kept fields");

  property p_cap_irq;
    @(posedge sys_clk) disable iff (rst)
      capture_strobe && s_q.ctrl.cap_mask && s_q.irq_mk[TM8_IRQ_CAP] && !stop_recovery
        |=> s_q.irq_st[TM8_IRQ_CAP] && irq;
  endproperty
  a_cap_irq: assert property (p_cap_irq) else $error("capture interrupt missing");

  property p_cnt_irq;
    @(posedge sys_clk) disable iff (rst)
      terminal && !s_q.ctrl.cnt_mask && !s_q.irq_st[TM8_IRQ_TOUT] && !wr_ctrl
        |=> !s_q.irq_st[TM8_IRQ_TOUT];
  endproperty
  a_cnt_irq: assert property (p_cnt_irq) else $error("masked time-out raised status");

  property p_pin;
    @(posedge sys_clk) disable iff (rst)
      !s_q.ctrl.route ##1 1'b1 |-> port3_pin4 == $past(port_data);
  endproperty
  a_pin: assert property (p_pin) else $error("pin not in port mode");

  property p_reset;
    @(posedge sys_clk)
      rst |=> (s_q.ctrl == TM8_CTRL_RST) && !port3_pin4 && !wb_ack_o;
  endproperty
  a_reset: assert property (p_reset) else $error("reset left control set");

  sequence s_start;
    run_any && !s_q.active && !stop_recovery;
  endsequence

  property p_start;
    @(posedge sys_clk) disable iff (rst)
      s_start |=> s_q.active;
  endproperty
  a_start: assert property (p_start) else $error("counter did not start");

  property p_load;
    @(posedge sys_clk) disable iff (rst)
      s_start |=> s_q.cnt == ($past(s_q.out) ? $past(s_q.hold_hi) : $past(s_q.hold_lo));
  endproperty
  a_load: assert property (p_load) else $error("wrong hold loaded");

  property p_halt_keep;
    @(posedge sys_clk) disable iff (rst)
      s_q.halted && run_any && !stop_recovery |=> s_q.halted && $stable(s_q.out);
  endproperty
  a_halt_keep: assert property (p_halt_keep) else $error("single pass restarted");

  property p_div8;
    @(posedge sys_clk) disable iff (rst)
      tick && (s_q.ctrl.presc == TM8_DIV8)
        |=> (!tick || (s_q.ctrl.presc != TM8_DIV8))[*7];
  endproperty
  a_div8: assert property (p_div8) else $error("divide by eight early");

  property p_smr_clear;
    @(posedge sys_clk) disable iff (rst)
      stop_recovery |=> !s_q.active && !s_q.ctrl.route && (s_q.irq_st == TM8_IRQ_RST);
  endproperty
  a_smr_clear: assert property (p_smr_clear) else $error("recovery left state");

  property p_cap_masked;
    @(posedge sys_clk) disable iff (rst)
      capture_strobe && !s_q.ctrl.cap_mask && !s_q.irq_st[TM8_IRQ_CAP]
        |=> !s_q.irq_st[TM8_IRQ_CAP];
  endproperty
  a_cap_masked: assert property (p_cap_masked) else $error("capture not masked");

  property p_tout_irq;
    @(posedge sys_clk) disable iff (rst)
      terminal && s_q.ctrl.cnt_mask && !stop_recovery |=> s_q.irq_st[TM8_IRQ_TOUT];
  endproperty
  a_tout_irq: assert property (p_tout_irq) else $error("time-out status missing");

  property p_route_timer;
    @(posedge sys_clk) disable iff (rst)
      s_q.ctrl.route |=> port3_pin4 == $past(s_q.out);
  endproperty
  a_route_timer: assert property (p_route_timer) else $error("pin not timer");

endmodule
`default_nettype wire

// >>> bench/tm8_tb.sv
// Self-checking testbench for the eight-bit timer control block
`timescale 1ns/1ps
`default_nettype none
module tb
  import tm8_pkg::*;
;
  localparam logic [15:0] A_CTRL = {TM8_IDX_CTRL, 2'b00};
  localparam logic [15:0] A_AUX  = {TM8_IDX_AUX, 2'b00};
  localparam logic [15:0] A_HLO  = {TM8_IDX_HLO, 2'b00};
  localparam logic [15:0] A_HHI  = {TM8_IDX_HHI, 2'b00};
  localparam logic [15:0] A_IST  = {TM8_IDX_IST, 2'b00};
  localparam logic [15:0] A_IMK  = {TM8_IDX_IMK, 2'b00};
  localparam logic [15:0] A_NONE = 16'h3500;

  logic        sys_clk;
  logic        rst;
  logic        wb_cyc_i;
  logic        wb_stb_i;
  logic        wb_we_i;
  logic [15:0] wb_adr_i;
  logic [3:0]  wb_sel_i;
  logic [31:0] wb_dat_i;
  logic [31:0] wb_dat_o;
  logic        wb_ack_o;
  logic        stop_recovery;
  logic        capture_strobe;
  logic        port_data;
  logic        port3_pin4;
  logic        irq;
  int          num_errors;
  int          total_checks;
  int          cycles;

  tm8_timer dut (
    .sys_clk        (sys_clk),
    .rst            (rst),
    .wb_cyc_i       (wb_cyc_i),
    .wb_stb_i       (wb_stb_i),
    .wb_we_i        (wb_we_i),
    .wb_adr_i       (wb_adr_i),
    .wb_sel_i       (wb_sel_i),
    .wb_dat_i       (wb_dat_i),
    .wb_dat_o       (wb_dat_o),
    .wb_ack_o       (wb_ack_o),
    .stop_recovery  (stop_recovery),
    .capture_strobe (capture_strobe),
    .port_data      (port_data),
    .port3_pin4     (port3_pin4),
    .irq            (irq)
  );

  initial
  begin
    sys_clk = 1'b0;
    forever #20 sys_clk = ~sys_clk;
  end

  task automatic wrap_up();
    $display("checks %0d errors %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  // Hang guard
  always @(posedge sys_clk)
  begin
    cycles <= cycles + 1;
    if (cycles == 20000)
    begin
      num_errors++;
      $display("Error t=%0t timeout", $time);
      wrap_up();
    end
  end

  task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string what);
    total_checks++;
    if (got !== exp)
    begin
      num_errors++;
      $display("Error t=%0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  // One classic cycle; entered just after a rising edge
  task automatic wb(input logic we, input logic [15:0] a, input logic [7:0] d,
                    output logic [7:0] r);
    int n;
    n = 0;
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i  <= we;
    wb_adr_i <= a;
    wb_dat_i <= {24'h00_0000, d};
    do
    begin
      @(posedge sys_clk);
      n++;
    end
    while (wb_ack_o !== 1'b1 && n < 50);
    chk({7'h00, wb_ack_o}, 8'h01, "ack");
    r = wb_dat_o[7:0];
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    wb_we_i  <= 1'b0;
    @(posedge sys_clk);
  endtask

  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    logic [7:0] r;
    wb(1'b1, a, d, r);
  endtask

  task automatic rd(input logic [15:0] a, input logic [7:0] exp, input string what);
    logic [7:0] r;
    wb(1'b0, a, 8'h00, r);
    chk(r, exp, what);
  endtask

  task automatic wait_pin(input logic lvl, output int n);
    n = 0;
    while (port3_pin4 !== lvl && n < 400)
    begin
      @(posedge sys_clk);
      n++;
    end
  endtask

  // Length of one high and one low output phase
  task automatic phases(output int hi, output int lo);
    int n;
    // Skip any partial phase left over from an earlier run
    wait_pin(1'b0, n);
    wait_pin(1'b1, n);
    wait_pin(1'b0, hi);
    wait_pin(1'b1, lo);
  endtask

  // One stop-mode recovery pulse; also returns the timer output to zero
  task automatic recover();
    stop_recovery <= 1'b1;
    @(posedge sys_clk);
    stop_recovery <= 1'b0;
    @(posedge sys_clk);
  endtask

  task automatic t_reset_map();
    rd(A_CTRL, 8'h00, "ctrl reset");
    rd(A_IST, 8'h00, "status reset");
    chk({6'h00, port3_pin4, irq}, 8'h00, "pin irq");
    wr(A_NONE, 8'h5a);
    rd(A_NONE, 8'h00, "unmapped");
    $display("test reset_map done");
  endtask

  task automatic t_route();
    port_data <= 1'b1;
    repeat (3) @(posedge sys_clk);
    chk({7'h00, port3_pin4}, 8'h01, "port mode 1");
    wr(A_CTRL, 8'h01);
    repeat (2) @(posedge sys_clk);
    chk({7'h00, port3_pin4}, 8'h00, "timer mode");
    wr(A_CTRL, 8'h00);
    port_data <= 1'b0;
    repeat (3) @(posedge sys_clk);
    chk({7'h00, port3_pin4}, 8'h00, "port mode 0");
    $display("test route done");
  endtask

  task automatic t_prescale();
    int hi;
    int lo;
    wr(A_HLO, 8'h03);
    wr(A_HHI, 8'h01);
    for (int p = 0; p < 4; p++)
    begin
      wr(A_CTRL, 8'h00);
      wr(A_CTRL, {3'b101, p[1:0], 3'b001});
      phases(hi, lo);
      chk(hi[7:0], 8'(2 << p), "high phase");
      chk(lo[7:0], 8'(4 << p), "low phase");
    end
    wr(A_CTRL, 8'h00);
    $display("test prescale done");
  endtask

  task automatic t_aux_run();
    int hi;
    int lo;
    logic pin;
    wr(A_CTRL, 8'h21);
    wr(A_AUX, 8'h40);
    phases(hi, lo);
    chk(hi[7:0], 8'h02, "aux run");
    wr(A_AUX, 8'h00);
    repeat (4) @(posedge sys_clk);
    pin = port3_pin4;
    repeat (40) @(posedge sys_clk);
    chk({7'h00, port3_pin4}, {7'h00, pin}, "stopped");
    wr(A_CTRL, 8'h00);
    $display("test aux_run done");
  endtask

  task automatic t_single();
    recover();
    wr(A_HLO, 8'h02);
    wr(A_CTRL, 8'he1);
    repeat (30) @(posedge sys_clk);
    chk({7'h00, port3_pin4}, 8'h01, "one pass");
    repeat (30) @(posedge sys_clk);
    chk({7'h00, port3_pin4}, 8'h01, "halted");
    rd(A_CTRL, 8'he1, "tout set");
    rd(A_IST, 8'h00, "cnt mask off");
    wr(A_CTRL, 8'hc1);
    rd(A_CTRL, 8'he1, "write 0 keeps");
    wr(A_CTRL, 8'he1);
    rd(A_CTRL, 8'hc1, "write 1 clears");
    wr(A_CTRL, 8'h00);
    $display("test single done");
  endtask

  task automatic t_irq();
    wr(A_HLO, 8'h01);
    wr(A_IMK, 8'h01);
    wr(A_CTRL, 8'he2);
    repeat (20) @(posedge sys_clk);
    chk({7'h00, irq}, 8'h01, "irq tout");
    rd(A_IST, 8'h01, "status tout");
    wr(A_IMK, 8'h00);
    chk({7'h00, irq}, 8'h00, "masked");
    wr(A_IMK, 8'h01);
    chk({7'h00, irq}, 8'h01, "unmasked");
    wr(A_IST, 8'h01);
    chk({7'h00, irq}, 8'h00, "cleared");
    wr(A_CTRL, 8'h04);
    wr(A_IMK, 8'h02);
    capture_strobe <= 1'b1;
    @(posedge sys_clk);
    capture_strobe <= 1'b0;
    repeat (2) @(posedge sys_clk);
    rd(A_IST, 8'h02, "capture status");
    chk({7'h00, irq}, 8'h01, "capture irq");
    wr(A_IST, 8'h02);
    wr(A_CTRL, 8'h00);
    capture_strobe <= 1'b1;
    @(posedge sys_clk);
    capture_strobe <= 1'b0;
    repeat (2) @(posedge sys_clk);
    rd(A_IST, 8'h00, "capture masked");
    chk({7'h00, irq}, 8'h00, "no irq");
    $display("test irq done");
  endtask

  task automatic t_stop();
    wr(A_CTRL, 8'hff);
    wr(A_AUX, 8'h40);
    recover();
    rd(A_CTRL, 8'h1e, "stop keeps");
    rd(A_AUX, 8'h00, "stop aux");
    rst <= 1'b1;
    repeat (2) @(posedge sys_clk);
    rst <= 1'b0;
    @(posedge sys_clk);
    rd(A_CTRL, 8'h00, "full reset");
    $display("test stop done");
  endtask

  initial
  begin
    rst            = 1'b1;
    wb_cyc_i       = 1'b0;
    wb_stb_i       = 1'b0;
    wb_we_i        = 1'b0;
    wb_adr_i       = 16'h0000;
    wb_sel_i       = 4'hf;
    wb_dat_i       = 32'h0000_0000;
    stop_recovery  = 1'b0;
    capture_strobe = 1'b0;
    port_data      = 1'b0;
    num_errors     = 0;
    total_checks   = 0;
    cycles         = 0;
    repeat (4) @(posedge sys_clk);
    rst <= 1'b0;
    @(posedge sys_clk);
    t_reset_map();
    t_route();
    t_prescale();
    t_aux_run();
    t_single();
    t_irq();
    t_stop();
    wrap_up();
  end
endmodule
`default_nettype wire
